/* File: rtl/scbm_pkg.sv */
package scbm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CHAN_W   = 8;
  localparam int HDR_W    = 40;
  localparam int OFFS_W   = 16;
  localparam int QUAL_W   = 8;
  localparam int CNT_W    = 8;
  localparam int TMO_W    = 20;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 250;
  localparam int OP_TMO_US    = 1000;
  localparam int OP_TMO_CYC   = OP_TMO_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CHAN_W-1:0] CHAN_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 8'h00;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCBM_SCAN_ONLY,
    SCBM_SCAN_OUTSIDE_BP,
    SCBM_SCAN_WHILE_INACTIVE,
    SCBM_SCAN_DISABLED
  } scbm_scan_state_t;

  typedef enum logic [1:0] {
    SCBM_SUCCESS,
    SCBM_FAILURE,
    SCBM_FAIL_NO_FREE_SLOTS
  } scbm_result_t;

  typedef enum logic [1:0] {
    SCBM_NEIGHBOUR,
    SCBM_ALIEN,
    SCBM_OWN
  } scbm_origin_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CHAN_W-1:0] channel_select;
    scbm_scan_state_t  scan_state;
  } scbm_scan_req_t;

  typedef struct packed {
    logic [HDR_W-1:0]  header;
    logic [CHAN_W-1:0] channel_select;
    logic [OFFS_W-1:0] beacon_start_offset_us;
    logic [QUAL_W-1:0] link_quality_value;
    logic [QUAL_W-1:0] rx_signal_strength_value;
  } scbm_rx_info_t;

  typedef struct packed {
    logic [CHAN_W-1:0] channel_select;
    logic [CNT_W-1:0]  chan_switch_announce_count;
  } scbm_chg_req_t;

endpackage : scbm_pkg

/* File: rtl/scbm_ctrl.sv */
// How it works
// - Scan request starts move to requested state
// - Scan confirm only after entry or failure
// - Scan timeout reports failure, else success
// - Header indication only while scan not disabled
// - Offset is sixteen bit microsecond count
// - Link quality and strength are eight bits
// - Beacon class is neighbour, alien or own
// - Start results: success, failure, fail_no_free_slots; stop: success, failure
// - Announce count is zero to 255
// - Merge countdown is zero to 255
// - Start request begins beacons on given channel
// - Start confirm after first beacon or failure
// - Start timeout reports failure
// - Stop request ends beacons at once
// - Stop success after one beacon-free period
// - Stop timeout reports failure
// - Channel change moves beacons and all frames
// - Change elements sent in count superframes
// - Switch at end of zero-countdown superframe
// - Four scan states, disabled after reset
// - Scan-only raises txrx_inhibit_q and stops beacon transmit; receive indications still pass
// - Change success after one good period
module scbm_ctrl #(
  parameter int unsigned TMO_CYCLES = scbm_pkg::OP_TMO_CYC
) (
  input  wire logic                              ref_clk,
  input  wire logic                              resetn,
  input  wire logic                              scan_req_valid,
  input  wire scbm_pkg::scbm_scan_req_t          scan_req,
  input  wire logic                              scan_entered,
  output logic                                   scan_cmd_valid_q,
  output scbm_pkg::scbm_scan_req_t               scan_cmd_q,
  output scbm_pkg::scbm_scan_state_t             scan_state_q,
  output logic                                   scan_cfm_valid_q,
  output scbm_pkg::scbm_result_t                 scan_cfm_result_q,
  output logic                                   txrx_inhibit_q,
  input  wire logic                              hdr_rx_valid,
  input  wire scbm_pkg::scbm_rx_info_t           hdr_rx,
  output logic                                   hdr_ind_valid_q,
  output scbm_pkg::scbm_rx_info_t                hdr_ind_q,
  input  wire logic                              start_req_valid,
  input  wire logic [scbm_pkg::CHAN_W-1:0]       start_req_channel,
  input  wire logic                              stop_req_valid,
  input  wire logic                              chg_req_valid,
  input  wire scbm_pkg::scbm_chg_req_t           chg_req,
  input  wire logic                              bp_start,
  input  wire logic                              sf_end,
  input  wire logic                              beacon_tx_ok,
  input  wire logic                              beacon_rx_ok,
  input  wire logic                              beacon_rx_alien,
  input  wire logic                              no_free_slots,
  output logic                                   beacon_tx_en_q,
  output logic [scbm_pkg::CHAN_W-1:0]            active_channel_q,
  output logic                                   chan_ie_en_q,
  output logic [scbm_pkg::CNT_W-1:0]             chan_countdown_q,
  output logic                                   start_cfm_valid_q,
  output logic                                   stop_cfm_valid_q,
  output logic                                   chg_cfm_valid_q,
  output scbm_pkg::scbm_result_t                 bcn_cfm_result_q,
  output logic                                   bcn_ind_valid_q,
  output scbm_pkg::scbm_origin_t                 beacon_origin_class_q,
  input  wire logic                              merge_ie_rx_valid,
  input  wire logic [scbm_pkg::CNT_W-1:0]        merge_ie_countdown,
  output logic                                   merge_ind_valid_q,
  output logic [scbm_pkg::CNT_W-1:0]             merge_countdown_q
);

  localparam logic [scbm_pkg::TMO_W-1:0] TMO_LAST = scbm_pkg::TMO_W'(TMO_CYCLES - 1);

  // ----------------------------------------------------------------
  // Scan state change
  // ----------------------------------------------------------------
  typedef enum logic {SCBM_SC_IDLE, SCBM_SC_WAIT} scbm_sc_t;

  scbm_sc_t                          sc_q, sc_d;
  scbm_pkg::scbm_scan_state_t        scan_state_d;
  scbm_pkg::scbm_scan_req_t          scan_cmd_d;
  logic                              scan_cmd_valid_d;
  logic [scbm_pkg::TMO_W-1:0]        scan_tmo_q, scan_tmo_d;
  logic                              scan_cfm_valid_d;
  scbm_pkg::scbm_result_t            scan_cfm_result_d;
  logic                              txrx_inhibit_d;

  always_comb begin
    sc_d              = sc_q;
    scan_state_d      = scan_state_q;
    scan_cmd_d        = scan_cmd_q;
    scan_cmd_valid_d  = 1'b0;
    scan_tmo_d        = scan_tmo_q;
    scan_cfm_valid_d  = 1'b0;
    scan_cfm_result_d = scan_cfm_result_q;
    unique case (sc_q)
      SCBM_SC_IDLE: begin
        if (scan_req_valid) begin
          sc_d             = SCBM_SC_WAIT;
          scan_cmd_d       = scan_req;
          scan_cmd_valid_d = 1'b1;
          scan_tmo_d       = '0;
        end
      end
      SCBM_SC_WAIT: begin
        scan_tmo_d = scan_tmo_q + 1'b1;
        if (scan_entered) begin
          sc_d              = SCBM_SC_IDLE;
          scan_state_d      = scan_cmd_q.scan_state;
          scan_cfm_valid_d  = 1'b1;
          scan_cfm_result_d = scbm_pkg::SCBM_SUCCESS;
        end else if (scan_tmo_q == TMO_LAST) begin
          sc_d              = SCBM_SC_IDLE;
          scan_cfm_valid_d  = 1'b1;
          scan_cfm_result_d = scbm_pkg::SCBM_FAILURE;
        end
      end
    endcase
    // Scan-only owns the radio; the beacon side is gated below as well
    txrx_inhibit_d = (scan_state_d == scbm_pkg::SCBM_SCAN_ONLY);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sc_q              <= SCBM_SC_IDLE;
      scan_state_q      <= scbm_pkg::SCBM_SCAN_DISABLED;
      scan_cmd_q        <= '{scbm_pkg::CHAN_RST, scbm_pkg::SCBM_SCAN_DISABLED};
      scan_cmd_valid_q  <= 1'b0;
      scan_tmo_q        <= '0;
      scan_cfm_valid_q  <= 1'b0;
      scan_cfm_result_q <= scbm_pkg::SCBM_SUCCESS;
      txrx_inhibit_q    <= 1'b0;
    end else begin
      sc_q              <= sc_d;
      scan_state_q      <= scan_state_d;
      scan_cmd_q        <= scan_cmd_d;
      scan_cmd_valid_q  <= scan_cmd_valid_d;
      scan_tmo_q        <= scan_tmo_d;
      scan_cfm_valid_q  <= scan_cfm_valid_d;
      scan_cfm_result_q <= scan_cfm_result_d;
      txrx_inhibit_q    <= txrx_inhibit_d;
    end
  end

  // ----------------------------------------------------------------
  // Beacon start, stop and channel change
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCBM_BC_OFF, SCBM_BC_STARTING, SCBM_BC_ON, SCBM_BC_STOPPING,
    SCBM_BC_ANNOUNCE, SCBM_BC_VERIFY
  } scbm_bc_t;

  scbm_bc_t                          bc_q, bc_d;
  logic                              beacon_tx_en_d;
  logic [scbm_pkg::CHAN_W-1:0]       active_channel_d, new_chan_q, new_chan_d;
  logic [scbm_pkg::CNT_W-1:0]        ie_cnt_q, ie_cnt_d;
  logic                              chan_ie_en_d;
  logic [scbm_pkg::CNT_W-1:0]        chan_countdown_d;
  logic                              bp_seen_q, bp_seen_d, tx_seen_q, tx_seen_d;
  logic                              rx_seen_q, rx_seen_d;
  logic [scbm_pkg::TMO_W-1:0]        bc_tmo_q, bc_tmo_d;
  logic                              start_cfm_d, stop_cfm_d, chg_cfm_d;
  scbm_pkg::scbm_result_t            bcn_res_d;
  logic                              bc_expire;

  assign bc_expire = (bc_tmo_q == TMO_LAST);

  always_comb begin
    bc_d             = bc_q;
    active_channel_d = active_channel_q;
    new_chan_d       = new_chan_q;
    ie_cnt_d         = ie_cnt_q;
    bp_seen_d        = bp_seen_q;
    tx_seen_d        = tx_seen_q | beacon_tx_ok;
    rx_seen_d        = rx_seen_q | beacon_rx_ok;
    bc_tmo_d         = bc_tmo_q + 1'b1;
    start_cfm_d      = 1'b0;
    stop_cfm_d       = 1'b0;
    chg_cfm_d        = 1'b0;
    bcn_res_d        = bcn_cfm_result_q;
    unique case (bc_q)
      SCBM_BC_OFF: begin
        if (start_req_valid) begin
          bc_d             = SCBM_BC_STARTING;
          active_channel_d = start_req_channel;
          bc_tmo_d         = '0;
        end
      end
      SCBM_BC_STARTING: begin
        if (beacon_tx_ok) begin
          bc_d        = SCBM_BC_ON;
          start_cfm_d = 1'b1;
          bcn_res_d   = scbm_pkg::SCBM_SUCCESS;
        end else if (no_free_slots) begin
          bc_d        = SCBM_BC_OFF;
          start_cfm_d = 1'b1;
          bcn_res_d   = scbm_pkg::SCBM_FAIL_NO_FREE_SLOTS;
        end else if (bc_expire) begin
          bc_d        = SCBM_BC_OFF;
          start_cfm_d = 1'b1;
          bcn_res_d   = scbm_pkg::SCBM_FAILURE;
        end
      end
      SCBM_BC_ON: begin
        if (stop_req_valid) begin
          bc_d      = SCBM_BC_STOPPING;
          bp_seen_d = 1'b0;
          tx_seen_d = 1'b0;
          bc_tmo_d  = '0;
        end else if (chg_req_valid) begin
          bc_d       = SCBM_BC_ANNOUNCE;
          new_chan_d = chg_req.channel_select;
          ie_cnt_d   = chg_req.chan_switch_announce_count;
        end
      end
      SCBM_BC_STOPPING: begin
        // A period counts only from its own start, so a partial one is skipped
        // A beacon on the period start belongs to the new period, so it is kept
        if (bp_start) begin
          bp_seen_d = 1'b1;
          tx_seen_d = beacon_tx_ok;
        end
        if (bp_start && bp_seen_q && !tx_seen_q) begin
          bc_d       = SCBM_BC_OFF;
          stop_cfm_d = 1'b1;
          bcn_res_d  = scbm_pkg::SCBM_SUCCESS;
        end else if (bc_expire) begin
          bc_d       = SCBM_BC_OFF;
          stop_cfm_d = 1'b1;
          bcn_res_d  = scbm_pkg::SCBM_FAILURE;
        end
      end
      SCBM_BC_ANNOUNCE: begin
        if (sf_end) begin
          if (ie_cnt_q <= 8'h01) begin
            bc_d             = SCBM_BC_VERIFY;
            active_channel_d = new_chan_q;
            bp_seen_d        = 1'b0;
            bc_tmo_d         = '0;
          end else begin
            ie_cnt_d = ie_cnt_q - 1'b1;
          end
        end
      end
      SCBM_BC_VERIFY: begin
        if (bp_start) begin
          bp_seen_d = 1'b1;
          tx_seen_d = beacon_tx_ok;
          rx_seen_d = beacon_rx_ok;
        end
        if (bp_start && bp_seen_q && tx_seen_q && rx_seen_q) begin
          bc_d      = SCBM_BC_ON;
          chg_cfm_d = 1'b1;
          bcn_res_d = scbm_pkg::SCBM_SUCCESS;
        end else if (bc_expire) begin
          bc_d      = SCBM_BC_ON;
          chg_cfm_d = 1'b1;
          bcn_res_d = scbm_pkg::SCBM_FAILURE;
        end
      end
      default: bc_d = SCBM_BC_OFF;
    endcase
    beacon_tx_en_d   = (bc_d != SCBM_BC_OFF) && (bc_d != SCBM_BC_STOPPING) && !txrx_inhibit_d;
    chan_ie_en_d     = (bc_d == SCBM_BC_ANNOUNCE) && (ie_cnt_d != 8'h00);
    chan_countdown_d = chan_ie_en_d ? ie_cnt_d - 1'b1 : scbm_pkg::CNT_RST;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bc_q              <= SCBM_BC_OFF;
      beacon_tx_en_q    <= 1'b0;
      active_channel_q  <= scbm_pkg::CHAN_RST;
      new_chan_q        <= scbm_pkg::CHAN_RST;
      ie_cnt_q          <= scbm_pkg::CNT_RST;
      chan_ie_en_q      <= 1'b0;
      chan_countdown_q  <= scbm_pkg::CNT_RST;
      bp_seen_q         <= 1'b0;
      tx_seen_q         <= 1'b0;
      rx_seen_q         <= 1'b0;
      bc_tmo_q          <= '0;
      start_cfm_valid_q <= 1'b0;
      stop_cfm_valid_q  <= 1'b0;
      chg_cfm_valid_q   <= 1'b0;
      bcn_cfm_result_q  <= scbm_pkg::SCBM_SUCCESS;
    end else begin
      bc_q              <= bc_d;
      beacon_tx_en_q    <= beacon_tx_en_d;
      active_channel_q  <= active_channel_d;
      new_chan_q        <= new_chan_d;
      ie_cnt_q          <= ie_cnt_d;
      chan_ie_en_q      <= chan_ie_en_d;
      chan_countdown_q  <= chan_countdown_d;
      bp_seen_q         <= bp_seen_d;
      tx_seen_q         <= tx_seen_d;
      rx_seen_q         <= rx_seen_d;
      bc_tmo_q          <= bc_tmo_d;
      start_cfm_valid_q <= start_cfm_d;
      stop_cfm_valid_q  <= stop_cfm_d;
      chg_cfm_valid_q   <= chg_cfm_d;
      bcn_cfm_result_q  <= bcn_res_d;
    end
  end

  // ----------------------------------------------------------------
  // Indications
  // ----------------------------------------------------------------
  logic                              hdr_ind_valid_d, bcn_ind_valid_d, merge_ind_valid_d;
  scbm_pkg::scbm_rx_info_t           hdr_ind_d;
  scbm_pkg::scbm_origin_t            origin_d;
  logic [scbm_pkg::CNT_W-1:0]        merge_countdown_d;

  always_comb begin
    hdr_ind_valid_d   = hdr_rx_valid && (scan_state_q != scbm_pkg::SCBM_SCAN_DISABLED);
    hdr_ind_d         = hdr_ind_valid_d ? hdr_rx : hdr_ind_q;
    bcn_ind_valid_d   = beacon_tx_ok || beacon_rx_ok;
    // Own transmission wins when both land in one cycle; the receive is dropped
    origin_d          = beacon_tx_ok    ? scbm_pkg::SCBM_OWN :
                        beacon_rx_alien ? scbm_pkg::SCBM_ALIEN : scbm_pkg::SCBM_NEIGHBOUR;
    if (!bcn_ind_valid_d) begin
      origin_d = beacon_origin_class_q;
    end
    merge_ind_valid_d = merge_ie_rx_valid;
    merge_countdown_d = merge_ie_rx_valid ? merge_ie_countdown : merge_countdown_q;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hdr_ind_valid_q       <= 1'b0;
      hdr_ind_q             <= '0;
      bcn_ind_valid_q       <= 1'b0;
      beacon_origin_class_q <= scbm_pkg::SCBM_NEIGHBOUR;
      merge_ind_valid_q     <= 1'b0;
      merge_countdown_q     <= scbm_pkg::CNT_RST;
    end else begin
      hdr_ind_valid_q       <= hdr_ind_valid_d;
      hdr_ind_q             <= hdr_ind_d;
      bcn_ind_valid_q       <= bcn_ind_valid_d;
      beacon_origin_class_q <= origin_d;
      merge_ind_valid_q     <= merge_ind_valid_d;
      merge_countdown_q     <= merge_countdown_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  scan_request_taken_a: assert property (sc_q == SCBM_SC_IDLE && scan_req_valid |=> scan_cmd_valid_q && scan_cmd_q == $past(scan_req)) else $error("scan request not forwarded");
  scan_cfm_cause_a: assert property (scan_cfm_valid_q |-> $past(sc_q) == SCBM_SC_WAIT && ($past(scan_entered) || $past(scan_tmo_q) == TMO_LAST)) else $error("scan confirm without cause");
  scan_cfm_result_a: assert property (scan_cfm_valid_q && scan_cfm_result_q == scbm_pkg::SCBM_SUCCESS |-> scan_state_q == scan_cmd_q.scan_state) else $error("scan success without state entry");
  hdr_gate_a: assert property (hdr_rx_valid && scan_state_q == scbm_pkg::SCBM_SCAN_DISABLED |=> !hdr_ind_valid_q) else $error("header indicated while scan disabled");
  scan_only_hold_a: assert property (scan_state_q == scbm_pkg::SCBM_SCAN_ONLY |-> txrx_inhibit_q && !beacon_tx_en_q) else $error("radio used during scan only");
  start_cfm_ok_a: assert property (start_cfm_valid_q && bcn_cfm_result_q == scbm_pkg::SCBM_SUCCESS |-> $past(beacon_tx_ok)) else $error("start confirm before first beacon");
  stop_now_a: assert property (bc_q == SCBM_BC_ON && stop_req_valid |=> !beacon_tx_en_q [*2]) else $error("beacons not stopped at once");
  stop_cfm_ok_a: assert property (stop_cfm_valid_q && bcn_cfm_result_q == scbm_pkg::SCBM_SUCCESS |-> $past(bp_seen_q) && !$past(tx_seen_q) && $past(bp_start)) else $error("stop confirm too early");
  chan_switch_a: assert property (bc_q == SCBM_BC_ANNOUNCE && sf_end && ie_cnt_q <= 8'h01 |=> active_channel_q == $past(new_chan_q) && bc_q == SCBM_BC_VERIFY) else $error("channel not switched at superframe end");
  ie_count_a: assert property (chan_ie_en_q |-> bc_q == SCBM_BC_ANNOUNCE && chan_countdown_q == ie_cnt_q - 8'h01) else $error("change element countdown wrong");
  chg_cfm_ok_a: assert property (chg_cfm_valid_q && bcn_cfm_result_q == scbm_pkg::SCBM_SUCCESS |-> $past(tx_seen_q) && $past(rx_seen_q)) else $error("change confirm without good period");

  scan_ok_c: cover property (scan_req_valid ##[1:20] scan_cfm_valid_q && scan_cfm_result_q == scbm_pkg::SCBM_SUCCESS);
  start_stop_c: cover property (start_cfm_valid_q ##[1:200] stop_cfm_valid_q);
  chg_ok_c: cover property (chg_cfm_valid_q && bcn_cfm_result_q == scbm_pkg::SCBM_SUCCESS);

endmodule : scbm_ctrl

/* File: testbench/scbm_dme_model.sv */
module scbm_dme_model (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     go,
  input  wire scbm_pkg::scbm_scan_req_t go_req,
  input  wire logic                     scan_cfm_valid_q,
  output logic                          scan_req_valid,
  output scbm_pkg::scbm_scan_req_t      scan_req,
  output logic                          busy_q
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle payload toggles so a stale request never looks valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      scan_req_valid <= 1'b0;
      scan_req       <= '0;
      busy_q         <= 1'b0;
    end else begin
      scan_req_valid <= go && !busy_q;
      if (go && !busy_q) begin
        scan_req <= go_req;
        busy_q   <= 1'b1;
      end else begin
        scan_req <= ~scan_req;
        if (scan_cfm_valid_q) busy_q <= 1'b0;
      end
    end
  end
endmodule : scbm_dme_model

/* File: testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 50;
  localparam int SE = 0, HV = 1, ST = 2, SP = 3, CG = 4, BP = 5;
  localparam int SF = 6, TX = 7, RX = 8, NS = 9, MG = 10;
  logic ref_clk = 1'b0, resetn = 1'b0, go = 1'b0, beacon_rx_alien = 1'b0;
  logic [10:0] pv = '0;
  logic scan_entered, hdr_rx_valid, start_req_valid, stop_req_valid, chg_req_valid;
  logic bp_start, sf_end, beacon_tx_ok, beacon_rx_ok, no_free_slots, merge_ie_rx_valid;
  logic scan_req_valid, scan_cmd_valid_q, scan_cfm_valid_q, txrx_inhibit_q, hdr_ind_valid_q;
  logic beacon_tx_en_q, chan_ie_en_q, start_cfm_valid_q, stop_cfm_valid_q, chg_cfm_valid_q;
  logic bcn_ind_valid_q, merge_ind_valid_q, busy_q;
  logic [4:0] wv;
  logic [7:0] start_req_channel = '0, merge_ie_countdown = '0, oc;
  logic [7:0] active_channel_q, chan_countdown_q, merge_countdown_q;
  scbm_pkg::scbm_scan_req_t   go_req = '0, scan_req, scan_cmd_q;
  scbm_pkg::scbm_scan_state_t scan_state_q;
  scbm_pkg::scbm_result_t     scan_cfm_result_q, bcn_cfm_result_q;
  scbm_pkg::scbm_origin_t     beacon_origin_class_q;
  scbm_pkg::scbm_rx_info_t    hdr_rx = '0, hdr_ind_q;
  scbm_pkg::scbm_chg_req_t    chg_req = '0;
  logic [31:0] seed = 32'h92EA, r;
  int fails = 0, cmp_count = 0, i, k, n, nc;
  int cnts[2] = '{0, 2};

  assign {merge_ie_rx_valid, no_free_slots, beacon_rx_ok, beacon_tx_ok, sf_end, bp_start,
          chg_req_valid, stop_req_valid, start_req_valid, hdr_rx_valid, scan_entered} = pv;
  always #2 ref_clk = ~ref_clk;
  // Waited-on strobes by index, so no task needs a reference argument
  assign wv = {start_cfm_valid_q, stop_cfm_valid_q, chg_cfm_valid_q, scan_cfm_valid_q,
               scan_cmd_valid_q};

  scbm_ctrl #(.TMO_CYCLES(TMO)) u_scbm_ctrl (.ref_clk, .resetn, .scan_req_valid, .scan_req,
    .scan_entered, .scan_cmd_valid_q, .scan_cmd_q, .scan_state_q, .scan_cfm_valid_q,
    .scan_cfm_result_q, .txrx_inhibit_q, .hdr_rx_valid, .hdr_rx, .hdr_ind_valid_q, .hdr_ind_q,
    .start_req_valid, .start_req_channel, .stop_req_valid, .chg_req_valid, .chg_req,
    .bp_start, .sf_end, .beacon_tx_ok, .beacon_rx_ok, .beacon_rx_alien, .no_free_slots,
    .beacon_tx_en_q, .active_channel_q, .chan_ie_en_q, .chan_countdown_q, .start_cfm_valid_q,
    .stop_cfm_valid_q, .chg_cfm_valid_q, .bcn_cfm_result_q, .bcn_ind_valid_q,
    .beacon_origin_class_q, .merge_ie_rx_valid, .merge_ie_countdown, .merge_ind_valid_q,
    .merge_countdown_q);
  scbm_dme_model u_scbm_dme_model (.ref_clk, .resetn, .go, .go_req, .scan_cfm_valid_q,
    .scan_req_valid, .scan_req, .busy_q);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic exp_ind(input logic [1:0] st);
    return st != 2'h3;
  endfunction : exp_ind
  task automatic chk(input logic [95:0] e, input logic [95:0] g);
    cmp_count++;
    if (e !== g) begin
      fails++;
      $display("unexpected at %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  // Strobes drop one edge after rising, so the design sees exactly one pulse
  task automatic pulse(input logic [10:0] m);
    @(posedge ref_clk);
    pv <= m;
    @(posedge ref_clk);
    pv <= '0;
    #1;
  endtask : pulse
  task automatic wait_hi(input int w, output int c);
    c = 0;
    while (wv[w] !== 1'b1 && c < 400) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    if (c >= 400) chk(0, 1);
  endtask : wait_hi
  task automatic hdr(input logic e);
    logic [95:0] h;
    h = {rnd(), rnd(), rnd()};
    hdr_rx <= h[79:0];
    pulse(11'(1 << HV));
    chk(e, hdr_ind_valid_q);
    if (e) chk(h[79:0], hdr_ind_q);
  endtask : hdr
  task automatic do_scan(input logic [1:0] st, input logic ok);
    logic [31:0] q;
    int c;
    q = rnd();
    @(posedge ref_clk);
    go <= 1'b1;
    go_req <= {q[7:0], st};
    @(posedge ref_clk);
    go <= 1'b0;
    wait_hi(0, c);
    chk(go_req, scan_cmd_q);
    chk(0, scan_cfm_valid_q);
    if (ok) pulse(11'(1 << SE));
    wait_hi(1, c);
    chk(!ok, scan_cfm_result_q);
    if (ok) chk(st, scan_state_q);
    if (!ok) chk(1, c > TMO - 3);
  endtask : do_scan
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk(3, scan_state_q);
    chk(0, beacon_tx_en_q);
    hdr(1'b0);
    r = rnd();
    merge_ie_countdown <= r[7:0];
    pulse(11'(1 << MG));
    chk({1'b1, r[7:0]}, {merge_ind_valid_q, merge_countdown_q});
    do_scan(2'h0, 1'b0);
    for (i = 0; i < 4; i++) begin
      do_scan(2'((i + 3) % 4), 1'b1);
      chk(i == 1, txrx_inhibit_q);
      hdr(exp_ind(2'((i + 3) % 4)));
    end
    $display("test scan done");
    r = rnd();
    start_req_channel <= r[7:0];
    pulse(11'(1 << ST));
    chk({1'b1, r[7:0], 1'b0}, {beacon_tx_en_q, active_channel_q, start_cfm_valid_q});
    pulse(11'(1 << TX));
    chk({1'b1, 2'h0, 2'h2}, {start_cfm_valid_q, bcn_cfm_result_q, beacon_origin_class_q});
    for (i = 0; i < 2; i++) begin
      beacon_rx_alien <= i[0];
      pulse(11'(1 << RX));
      chk({1'b1, 2'(i)}, {bcn_ind_valid_q, beacon_origin_class_q});
    end
    do_scan(2'h0, 1'b1);
    chk(0, beacon_tx_en_q);
    do_scan(2'h2, 1'b1);
    chk(1, beacon_tx_en_q);
    $display("test start done");
    foreach (cnts[j]) begin
      r = rnd();
      nc = cnts[j];
      oc = active_channel_q;
      chg_req <= {r[7:0], 8'(nc)};
      pulse(11'(1 << CG));
      for (k = (nc > 0 ? nc : 1) - 1; k >= 0; k--) begin
        chk(nc != 0, chan_ie_en_q);
        if (nc != 0) chk(k, chan_countdown_q);
        chk(oc, active_channel_q);
        pulse(11'(1 << SF));
      end
      chk({r[7:0], 1'b0}, {active_channel_q, chan_ie_en_q});
      pulse(11'(1 << BP));
      pulse(11'(3 << TX));
      chk(0, chg_cfm_valid_q);
      pulse(11'(1 << BP));
      wait_hi(2, n);
      chk(1, n <= 1);
    end
    $display("test change done");
    pulse(11'(1 << SP));
    chk(0, beacon_tx_en_q);
    wait_hi(3, n);
    chk({1'b1, 2'h1}, {n > TMO - 3, bcn_cfm_result_q});
    pulse(11'(1 << ST));
    pulse(11'(1 << TX));
    pulse(11'(1 << SP));
    chk(0, beacon_tx_en_q);
    pulse(11'(1 << BP));
    chk(0, stop_cfm_valid_q);
    pulse(11'(1 << BP));
    wait_hi(3, n);
    chk({1'b1, 2'h0}, {n <= 1, bcn_cfm_result_q});
    pulse(11'(1 << ST));
    pulse(11'(1 << NS));
    wait_hi(4, n);
    chk(2, bcn_cfm_result_q);
    pulse(11'(1 << ST));
    wait_hi(4, n);
    chk({1'b1, 2'h1}, {n > TMO - 3, bcn_cfm_result_q});
    $display("test stop done");
    tally_and_finish();
  end

  // A hang shows as a counted mismatch, not a silent stall
  initial begin
    #40000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_top
